// [tx_sel_pkg.sv]
// constants and types shared by the transmit channel selection block
package tx_sel_pkg;

    // register byte offsets
    localparam logic [7:0] TX_CHAN_EN_A_OFS  = 8'h00;
    localparam logic [7:0] TX_CHAN_EN_H_OFS  = 8'h1C;
    localparam logic [7:0] TX_CTRL_OFS       = 8'h20;
    localparam logic [7:0] SLOT_STATUS_OFS   = 8'h24;

    // control register field positions
    localparam int MODE_LSB      = 0;
    localparam int RANGE_EXT_BIT = 2;
    localparam int PART_A_LSB    = 4;
    localparam int PART_B_LSB    = 8;

    // status register field positions
    localparam int STAT_ENABLED_BIT = 8;
    localparam int STAT_UNMASK_BIT  = 9;
    localparam int STAT_ACTIVE_BIT  = 10;

    // reset values
    localparam logic [15:0] CHAN_EN_RESET = 16'h0000;
    localparam logic [1:0]  MODE_RESET    = 2'h0;
    localparam logic [2:0]  BLOCK_RESET   = 3'h0;

    // partitions, bits per partition, channels
    localparam int NUM_PARTS     = 8;
    localparam int PART_BITS     = 16;
    localparam int NUM_CHANS     = 128;
    localparam int SLOT_BITS     = 16;
    localparam logic [6:0] LAST_CHAN     = 7'h7F;
    localparam logic [4:0] LAST_SLOT_BIT = 5'h0F;

    typedef enum logic [1:0] {
        MODE_ALL       = 2'h0,
        MODE_SELECT    = 2'h1,
        MODE_MASKED    = 2'h2,
        MODE_SYMMETRIC = 2'h3
    } tx_multichan_mode_t;

endpackage

// [sel_if.sv]
// signals passed between the register file, the slot tracker and the core
`timescale 1ns/100ps
interface sel_if;
    logic [7:0][15:0]          tx_chan_enable_reg;
    tx_sel_pkg::tx_multichan_mode_t tx_multichan_mode;
    logic                      tx_chan_range_ext;
    logic [2:0]                tx_part_a_block_sel;
    logic [2:0]                tx_part_b_block_sel;
    logic [6:0]                chan;
    logic                      slot_start;
    logic                      frame_active;
    logic                      chan_enabled;
    logic                      chan_unmasked;

    modport regs (
        output tx_chan_enable_reg, tx_multichan_mode, tx_chan_range_ext,
        output tx_part_a_block_sel, tx_part_b_block_sel,
        input  chan, frame_active, chan_enabled, chan_unmasked
    );
    modport track (
        output chan, slot_start, frame_active
    );
    modport core (
        input  tx_chan_enable_reg, tx_multichan_mode, tx_chan_range_ext,
        input  tx_part_a_block_sel, tx_part_b_block_sel,
        input  chan, slot_start, frame_active,
        output chan_enabled, chan_unmasked
    );
endinterface

// [apb_regs.sv]
// apb slave holding the channel enable and control registers
`timescale 1ns/100ps
module apb_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // block side
    sel_if.regs              sel
);
    logic [7:0][15:0] chan_en_q;
    logic [10:0]      ctrl_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;

    wire       setup_w   = psel && !penable;
    wire       access_w  = psel && penable && pready_q;
    wire       is_chan_w = paddr <= tx_sel_pkg::TX_CHAN_EN_H_OFS &&
                           paddr[1:0] == 2'h0;
    wire       is_ctrl_w = paddr == tx_sel_pkg::TX_CTRL_OFS;
    wire       is_stat_w = paddr == tx_sel_pkg::SLOT_STATUS_OFS;
    wire       mapped_w  = is_chan_w || is_ctrl_w || is_stat_w;
    wire [2:0] idx_w     = paddr[4:2];
    wire       wr_w      = access_w && pwrite;

    wire [31:0] status_w = {21'h0, sel.frame_active, sel.chan_unmasked,
                            sel.chan_enabled, 1'b0, sel.chan};
    wire [31:0] rd_w = is_chan_w ? {16'h0, chan_en_q[idx_w]} :
                       is_ctrl_w ? {21'h0, ctrl_q} :
                       is_stat_w ? status_w : 32'h0;

    // every channel bit is read/write and resets to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_en_q <= {tx_sel_pkg::NUM_PARTS{tx_sel_pkg::CHAN_EN_RESET}};
        end else if (wr_w && is_chan_w) begin
            if (pstrb[0]) chan_en_q[idx_w][7:0]  <= pwdata[7:0];
            if (pstrb[1]) chan_en_q[idx_w][15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= {tx_sel_pkg::BLOCK_RESET, 1'b0, tx_sel_pkg::BLOCK_RESET,
                       2'h0, tx_sel_pkg::MODE_RESET};
        end else if (wr_w && is_ctrl_w) begin
            if (pstrb[0]) ctrl_q[6:0]  <= {pwdata[6:4], 1'b0, pwdata[2:0]};
            if (pstrb[1]) ctrl_q[10:8] <= pwdata[10:8];
        end
    end

    // answer in the first access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= (setup_w && !pwrite) ? rd_w : 32'h0;
            pready_q  <= setup_w;
            pslverr_q <= setup_w && (!mapped_w || (pwrite && is_stat_w));
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    assign sel.tx_chan_enable_reg  = chan_en_q;
    assign sel.tx_multichan_mode   =
        tx_sel_pkg::tx_multichan_mode_t'(ctrl_q[tx_sel_pkg::MODE_LSB +: 2]);
    assign sel.tx_chan_range_ext   = ctrl_q[tx_sel_pkg::RANGE_EXT_BIT];
    assign sel.tx_part_a_block_sel = ctrl_q[tx_sel_pkg::PART_A_LSB +: 3];
    assign sel.tx_part_b_block_sel = ctrl_q[tx_sel_pkg::PART_B_LSB +: 3];
endmodule

// [slot_tracker.sv]
// samples the link clock and frame sync and counts time slots
`timescale 1ns/100ps
module slot_tracker (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // link pins
    input  wire logic link_clk_pin,
    input  wire logic frame_sync_pin,
    // block side
    sel_if.track      sel
);
    logic [1:0] lclk_sync_q;
    logic [1:0] fs_sync_q;
    logic       lclk_prev_q;
    logic [4:0] bit_q;
    logic [6:0] chan_q;
    logic       active_q;
    logic       start_q;

    wire rise_w     = lclk_sync_q[1] && !lclk_prev_q;
    wire slot_end_w = bit_q == tx_sel_pkg::LAST_SLOT_BIT;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lclk_sync_q <= 2'h0;
            fs_sync_q   <= 2'h0;
            lclk_prev_q <= 1'b0;
        end else begin
            lclk_sync_q <= {lclk_sync_q[0], link_clk_pin};
            fs_sync_q   <= {fs_sync_q[0], frame_sync_pin};
            lclk_prev_q <= lclk_sync_q[1];
        end
    end

    // frame sync on a link rising edge opens channel 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_q    <= 5'h0;
            chan_q   <= 7'h0;
            active_q <= 1'b0;
            start_q  <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (rise_w && fs_sync_q[1]) begin
                bit_q    <= 5'h0;
                chan_q   <= 7'h0;
                active_q <= 1'b1;
                start_q  <= 1'b1;
            end else if (rise_w && active_q) begin
                bit_q <= slot_end_w ? 5'h0 : bit_q + 5'h1;
                if (slot_end_w) begin
                    chan_q   <= chan_q + 7'h1;
                    active_q <= chan_q != tx_sel_pkg::LAST_CHAN;
                    start_q  <= chan_q != tx_sel_pkg::LAST_CHAN;
                end
            end
        end
    end

    assign sel.chan         = chan_q;
    assign sel.slot_start   = start_q;
    assign sel.frame_active = active_q;
endmodule

// [tx_multichannel_select.sv]
// transmit multichannel selection: decides per slot what reaches the line
`timescale 1ns/100ps
module tx_multichannel_select (
    // clock and reset
    input  wire logic         CLK,
    input  wire logic         RST_N,
    // apb slave
    input  wire logic [7:0]   PADDR,
    input  wire logic         PSEL,
    input  wire logic         PENABLE,
    input  wire logic         PWRITE,
    input  wire logic [31:0]  PWDATA,
    input  wire logic [3:0]   PSTRB,
    output logic      [31:0]  PRDATA,
    output logic              PREADY,
    output logic              PSLVERR,
    // receive side configuration
    input  wire logic [127:0] RX_CHAN_EN,
    input  wire logic [2:0]   RX_PART_A_SEL,
    input  wire logic [2:0]   RX_PART_B_SEL,
    // transmitter bit stream
    input  wire logic         TX_BIT,
    // link pins
    input  wire logic         LINK_CLK,
    input  wire logic         FRAME_SYNC,
    output logic              SERIAL_DATA_OUT,
    output logic              SERIAL_DATA_OE,
    // slot status to the transmitter
    output logic              CHAN_ENABLED,
    output logic [6:0]        CHAN_INDEX
);
    sel_if sel ();

    apb_regs u_regs (
        .clk     (CLK),
        .rst_n   (RST_N),
        .paddr   (PADDR),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .pwdata  (PWDATA),
        .pstrb   (PSTRB),
        .prdata  (PRDATA),
        .pready  (PREADY),
        .pslverr (PSLVERR),
        .sel     (sel.regs)
    );

    slot_tracker u_track (
        .clk            (CLK),
        .rst_n          (RST_N),
        .link_clk_pin   (LINK_CLK),
        .frame_sync_pin (FRAME_SYNC),
        .sel            (sel.track)
    );

    logic [127:0] tx_bits_w;
    logic [127:0] rx_bits_w;
    logic [127:0] enabled_w;
    logic [127:0] unmasked_w;
    logic         en_q;
    logic         unmask_q;
    logic         out_q;
    logic         oe_q;
    logic         chan_en_out_q;
    logic [6:0]   chan_q;

    wire       symmetric_w = sel.tx_multichan_mode == tx_sel_pkg::MODE_SYMMETRIC;
    // block of partition A and B depends on the mode
    wire [2:0] blk_a_w = symmetric_w ? RX_PART_A_SEL
                                     : sel.tx_part_a_block_sel;
    wire [2:0] blk_b_w = symmetric_w ? RX_PART_B_SEL
                                     : sel.tx_part_b_block_sel;

    // per channel: transmit bit, receive enable, enabled and unmasked
    genvar c;
    generate
        for (c = 0; c < tx_sel_pkg::NUM_CHANS; c++) begin : g_chan
            localparam logic [2:0] BLK = 3'(c / tx_sel_pkg::PART_BITS);
            localparam int         K   = c % tx_sel_pkg::PART_BITS;
            wire in_a = BLK == blk_a_w;
            wire in_b = BLK == blk_b_w && !in_a;
            wire tx32 = in_a ? sel.tx_chan_enable_reg[0][K] :
                        in_b ? sel.tx_chan_enable_reg[1][K] :
                        1'b0;
            wire rx32 = in_a ? RX_CHAN_EN[K] :
                        in_b ? RX_CHAN_EN[tx_sel_pkg::PART_BITS + K] : 1'b0;
            // 128 channels map block by block, 32 use A and B only
            assign tx_bits_w[c] = sel.tx_chan_range_ext
                                ? sel.tx_chan_enable_reg[BLK][K] : tx32;
            assign rx_bits_w[c] = sel.tx_chan_range_ext
                                ? RX_CHAN_EN[c] : rx32;
        end
    endgenerate

    always_comb begin
        unique case (sel.tx_multichan_mode)
            tx_sel_pkg::MODE_ALL: begin
                enabled_w  = '1;
                unmasked_w = '1;
            end
            tx_sel_pkg::MODE_SELECT: begin
                enabled_w  = tx_bits_w;
                unmasked_w = tx_bits_w;
            end
            tx_sel_pkg::MODE_MASKED: begin
                enabled_w  = '1;
                unmasked_w = tx_bits_w;
            end
            tx_sel_pkg::MODE_SYMMETRIC: begin
                enabled_w  = rx_bits_w;
                unmasked_w = tx_bits_w;
            end
        endcase
    end

    // latch the decision at the start of each slot
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_q     <= 1'b0;
            unmask_q <= 1'b0;
            chan_q   <= 7'h0;
        end else if (sel.slot_start) begin
            en_q     <= enabled_w[sel.chan];
            unmask_q <= unmasked_w[sel.chan];
            chan_q   <= sel.chan;
        end
    end

    // drive only for enabled and unmasked slots of an open frame
    wire drive_w = sel.frame_active && en_q && unmask_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_q         <= 1'b0;
            oe_q          <= 1'b0;
            chan_en_out_q <= 1'b0;
        end else begin
            out_q         <= drive_w && TX_BIT;
            oe_q          <= drive_w;
            chan_en_out_q <= sel.frame_active && en_q;
        end
    end

    assign sel.chan_enabled  = en_q;
    assign sel.chan_unmasked = unmask_q;

    assign SERIAL_DATA_OUT = out_q;
    assign SERIAL_DATA_OE  = oe_q;
    assign CHAN_ENABLED    = chan_en_out_q;
    assign CHAN_INDEX      = chan_q;
endmodule

// [tdm_peer.sv]
// serial peer that clocks short frames and marks the middle of each slot
`timescale 1ns/100ps
module tdm_peer (
    // link pins
    output logic link_clk,
    output logic frame_sync,
    // slot marker
    output logic mid,
    output int   slot
);
    initial begin
        link_clk = 1'b0;
        frame_sync = 1'b0;
        mid = 1'b0;
        slot = 0;
    end

    // clock runs only inside a frame, sync seen at the first rise
    task automatic run(input int nslot);
        frame_sync = 1'b1;
        for (int r = 0; r < nslot * 16; r++) begin
            #62.5 link_clk = 1'b1;
            slot = r / 16;
            mid = (r % 16 == 8);
            #62.5 link_clk = 1'b0;
            frame_sync = 1'b0;
        end
        #62.5 mid = 1'b0;
    endtask
endmodule

// [tx_multichannel_select_chk.sv]
// port checker for the transmit channel selection block
`timescale 1ns/100ps
module tx_multichannel_select_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // apb
    input wire logic [7:0]  PADDR,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // line side
    input wire logic        TX_BIT,
    input wire logic        SERIAL_DATA_OUT,
    input wire logic        SERIAL_DATA_OE,
    input wire logic        CHAN_ENABLED,
    input wire logic [6:0]  CHAN_INDEX
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy_acc;
        PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE);
    endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("stray ready");
    property p_err;
        PSEL && !PENABLE && PADDR > 8'h24 |=> PSLVERR && PRDATA == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_ok;
        PSEL && !PENABLE && PADDR <= 8'h20 && PADDR[1:0] == 2'h0
            |=> !PSLVERR;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped refused");
    property p_hi; PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_oe; SERIAL_DATA_OE |-> CHAN_ENABLED; endproperty
    a_oe: assert property (p_oe) else $error("drive while off");
    property p_dat;
        SERIAL_DATA_OE |-> SERIAL_DATA_OUT == $past(TX_BIT);
    endproperty
    a_dat: assert property (p_dat) else $error("data lag wrong");
    property p_quiet; !SERIAL_DATA_OE |-> !SERIAL_DATA_OUT; endproperty
    a_quiet: assert property (p_quiet) else $error("data when idle");
    property p_idx;
        $changed(CHAN_INDEX) |->
            CHAN_INDEX == 7'h00 || CHAN_INDEX == $past(CHAN_INDEX) + 7'h01;
    endproperty
    a_idx: assert property (p_idx) else $error("slot order wrong");
endmodule

bind tx_multichannel_select tx_multichannel_select_chk i_chk (.*);

// [tx_multichannel_select_bench.sv]
// self-checking bench for the transmit channel selection block
`timescale 1ns/100ps
module tx_multichannel_select_bench;
    localparam int NSLOT = 36;
    logic         CLK, RST_N, PSEL, PENABLE, PWRITE, TX_BIT, mid, tx_prev;
    logic         PREADY, PSLVERR, LINK_CLK, FRAME_SYNC;
    logic         SERIAL_DATA_OUT, SERIAL_DATA_OE, CHAN_ENABLED;
    logic [7:0]   PADDR;
    logic [31:0]  PWDATA, PRDATA;
    logic [127:0] RX_CHAN_EN;
    logic [2:0]   RX_PART_A_SEL, RX_PART_B_SEL;
    logic [6:0]   CHAN_INDEX;
    logic [15:0]  xc [8];
    int           errors, checks, cycles, slot, mode, ext, pa, pb;
    int           seed = 32'h7915;
    int           tm [7] = '{0, 1, 2, 3, 1, 3, 2};
    int           te [7] = '{0, 0, 1, 0, 1, 1, 0};

    tx_multichannel_select i_tx_multichannel_select (.PSTRB(4'hF), .*);
    tdm_peer i_tdm_peer (.link_clk(LINK_CLK), .frame_sync(FRAME_SYNC),
                         .mid(mid), .slot(slot));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        TX_BIT <= 1'($random(seed));
        tx_prev <= TX_BIT;
        cycles <= cycles + 1;
        if (cycles > 60000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: reg %h exp %h", $time, got, exp);
        end
    endtask

    // channel decision worked out from the mode, range and block selects
    function automatic logic [1:0] model(input int c);
        int   blk, sa, sb;
        logic t, r;
        blk = c / 16;
        sa = (mode == 3) ? RX_PART_A_SEL : pa;
        sb = (mode == 3) ? RX_PART_B_SEL : pb;
        if (mode == 0) return 2'b11;
        if (ext != 0) begin
            t = xc[blk][c % 16];
            r = RX_CHAN_EN[c];
        end else if (blk == sa) begin
            t = xc[0][c % 16];
            r = RX_CHAN_EN[c % 16];
        end else if (blk == sb) begin
            t = xc[1][c % 16];
            r = RX_CHAN_EN[16 + c % 16];
        end else
            return (mode == 2) ? 2'b10 : 2'b00;
        if (mode == 1) return {t, t};
        if (mode == 2) return {1'b1, t};
        return {r, t};
    endfunction

    task automatic cmp_slot(input int c);
        logic [1:0] m;
        m = model(c);
        checks++;
        if (CHAN_INDEX !== 7'(c) || CHAN_ENABLED !== m[1]
            || SERIAL_DATA_OE !== (m[1] & m[0])
            || SERIAL_DATA_OUT !== (m[1] & m[0] & tx_prev)) begin
            errors++;
            $display("wrong value at %0t: slot %0d", $time, c);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] xr,
                       input logic xe);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        if (!w) cmp_reg(PRDATA, xr);
        cmp_reg({31'h0, PSLVERR}, {31'h0, xe});
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic run_test(input int k);
        logic [31:0] ctrl;
        mode = tm[k];
        ext = te[k];
        pa = $unsigned($random(seed)) % 3;
        pb = $unsigned($random(seed)) % 3;
        RX_PART_A_SEL <= 3'($unsigned($random(seed)) % 3);
        RX_PART_B_SEL <= 3'($unsigned($random(seed)) % 3);
        RX_CHAN_EN <= {4{$random(seed)}};
        for (int i = 0; i < 8; i++) begin
            xc[i] = 16'($random(seed));
            apb(1, 8'(4 * i), {16'h0, xc[i]}, 0, 0);
            apb(0, 8'(4 * i), 0, {16'h0, xc[i]}, 0);
        end
        ctrl = 32'(mode | ext << 2 | pa << 4 | pb << 8);
        apb(1, 8'h20, ctrl, 0, 0);
        apb(0, 8'h20, 0, ctrl, 0);
        fork
            i_tdm_peer.run(NSLOT);
            for (int s = 0; s < NSLOT; s++) begin
                @(posedge mid);
                @(negedge CLK);
                cmp_slot(slot);
            end
        join
        @(posedge CLK);
        $display("test %0d done", k);
    endtask

    initial begin
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        TX_BIT = 1'b0;
        RX_CHAN_EN = '0;
        RX_PART_A_SEL = 3'h0;
        RX_PART_B_SEL = 3'h0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        for (int i = 0; i < 8; i++)
            apb(0, 8'(4 * i), 0, 0, 0);
        apb(0, 8'h20, 0, 0, 0);
        apb(0, 8'h24, 0, 0, 0);
        apb(0, 8'h28, 0, 0, 1);
        apb(1, 8'h24, 32'h1, 0, 1);
        $display("test reset done");
        for (int k = 0; k < 7; k++)
            run_test(k);
        give_verdict();
    end
endmodule
